// File: shared/supervisor_pkg.sv
// Package: timing, register map and fields of the supervisor
package supervisor_pkg;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_HZ         = 25_000_000;
   localparam int unsigned RESET_MS       = 200;
   localparam int unsigned WDOG_MS        = 1600;
   localparam int unsigned CE_GATE_US     = 28;
   localparam int unsigned RESET_CYC      = (CLK_HZ / 1000) * RESET_MS;
   localparam int unsigned WDOG_CYC       = (CLK_HZ / 1000) * WDOG_MS;
   localparam int unsigned CE_GATE_CYC    = ((CLK_HZ / 1_000_000) * CE_GATE_US > 0) ?
                                            (CLK_HZ / 1_000_000) * CE_GATE_US : 1;
   localparam int unsigned CNT_W          = 32;
   localparam int unsigned SYNC_STAGES    = 2;
   // ---------------------------------------------------------------
   // Register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_STATUS     = 8'h00;
   localparam logic [7:0] ADDR_IRQ_STAT   = 8'h04;
   localparam logic [7:0] ADDR_IRQ_MASK   = 8'h08;
   localparam logic [7:0] ADDR_CONTROL    = 8'h0C;
   localparam int unsigned EV_W           = 5;
   localparam logic [EV_W-1:0] MASK_RST   = 5'h1f;
   localparam logic [31:0] CTRL_RST       = 32'h0000_0000;
   localparam logic [1:0] RESP_OKAY       = 2'b00;
   localparam logic [1:0] RESP_DECERR     = 2'b11;
   // Event bits, also status bit positions for reset, watchdog and low-line only
   localparam int unsigned EV_RESET       = 0;
   localparam int unsigned EV_WDOG        = 1;
   localparam int unsigned EV_PFAIL       = 2;
   localparam int unsigned EV_LOWLINE     = 3;
   localparam int unsigned EV_BACKUP      = 4;
   // Control bit: software reset request
   localparam int unsigned CTRL_SWRST     = 0;

   // Analog comparator results, already digital
   typedef struct packed {
      logic supply_below_rst;   // Supply under reset threshold
      logic supply_below_low;   // Supply under low-line threshold
      logic supply_below_backup_cell_input;  // Supply under battery voltage
      logic backup_cell_input_above_ok;      // Battery over its good threshold
      logic pfail_below;        // Power-fail input under threshold
   } sense_type;

   typedef struct packed {
      logic backup_sel;
      logic backup_cell_input_good;
      logic pfail_n;
      logic lowline_n;
      logic wdog_fault_n;
      logic ce_gate_en;
      logic reset_n;
   } state_type;
endpackage : supervisor_pkg

// File: src/sync_bits.sv
// Two-stage synchroniser for a group of level inputs
`timescale 1ns/1ps
module sync_bits #(
   parameter int unsigned WIDTH = 1
) (
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             srst,
   // Levels
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] meta_r;
   initial begin
      if (WIDTH < 1) $error("sync_bits: WIDTH must be at least 1");
   end
   // First stage feeds only the second stage
   always_ff @(posedge core_clk) begin
      if (srst) begin
         meta_r <= '0;
         dout   <= '0;
      end else begin
         meta_r <= din;
         dout   <= meta_r;
      end
   end
endmodule : sync_bits

// File: src/delay_counter.sv
// Restartable delay counter: done after LIMIT cycles of run
`timescale 1ns/1ps
module delay_counter #(
   parameter int unsigned WIDTH = 32,
   parameter int unsigned LIMIT = 10
) (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic srst,
   // Control
   input  wire logic clear,
   input  wire logic run,
   output logic      done
);
   logic [WIDTH-1:0] cnt_r;
   localparam logic [WIDTH-1:0] LIM = WIDTH'(LIMIT);
   initial begin
      if (LIMIT < 1 || WIDTH < 2 || LIMIT >= (64'd1 << WIDTH))
         $error("delay_counter: LIMIT does not fit");
   end
   assign done = (cnt_r >= LIM);
   always_ff @(posedge core_clk) begin
      if (srst || clear) begin
         cnt_r <= '0;
      end else if (run && !done) begin
         cnt_r <= cnt_r + WIDTH'(1);
      end
   end
endmodule : delay_counter

// File: src/supervisor_reset_watchdog.sv
// Supervisor top: reset stretch, watchdog, warnings, CE gating, backup, AXI4-Lite
//
// Functional notes
// - Manual reset low asserts reset; held until 200ms after it returns high.
// - Reset low while supply below threshold, and 200ms after it recovers.
// - Active-high reset output is always the inverse of active-low one.
// - Watchdog fault low when kick input idle beyond 1.6s, until next edge.
// - Watchdog fault held high while reset is asserted.
// - Floating kick input disables watchdog; fault output stays high.
// - Power-fail warning low while sensed voltage below its threshold.
// - Early supply warning low once supply under low-line threshold.
// - Disabled chip-enable gate forces chip select output inactive high.
// - Backup-selected flag high while RAM supply is on the battery.
// - Battery chosen only when supply below reset threshold and battery voltage.
// - Battery-good high in normal operation when battery over its threshold.
// - Watchdog timer cleared in reset, counts after release, restarts on edges.
// - Supply dip during the stretch restarts the 200ms timeout.
// - CE gate disabled 28us after reset on power-down, until reset ends.
//
// The AXI4-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module supervisor_reset_watchdog
   import supervisor_pkg::*;
#(
   parameter int unsigned RESET_CYCLES = supervisor_pkg::RESET_CYC,
   parameter int unsigned WDOG_CYCLES  = supervisor_pkg::WDOG_CYC,
   parameter int unsigned CE_CYCLES    = supervisor_pkg::CE_GATE_CYC
) (
   // Clock and reset
   input  wire logic                     core_clk,
   input  wire logic                     srst,
   // Comparator indications
   input  wire supervisor_pkg::sense_type sense_in,
   // Processor side pins
   input  wire logic                     manual_reset_n,
   input  wire logic                     watchdog_kick_in,
   input  wire logic                     watchdog_kick_float,
   input  wire logic                     chip_select_in,
   output logic                          reset_out_n,
   output logic                          reset_out,
   output logic                          watchdog_fault_n,
   output logic                          powerfail_warn_n,
   output logic                          early_supply_warn_n,
   output logic                          chip_select_out,
   output logic                          backup_cell_selected,
   output logic                          backup_cell_good,
   output logic                          irq,
   // AXI4-Lite slave
   input  wire logic [7:0]               s_awaddr,
   input  wire logic                     s_awvalid,
   output logic                          s_awready,
   input  wire logic [31:0]              s_wdata,
   input  wire logic [3:0]               s_wstrb,
   input  wire logic                     s_wvalid,
   output logic                          s_wready,
   output logic [1:0]                    s_bresp,
   output logic                          s_bvalid,
   input  wire logic                     s_bready,
   input  wire logic [7:0]               s_araddr,
   input  wire logic                     s_arvalid,
   output logic                          s_arready,
   output logic [31:0]                   s_rdata,
   output logic [1:0]                    s_rresp,
   output logic                          s_rvalid,
   input  wire logic                     s_rready
);
   import supervisor_pkg::*;

   initial begin
      if (RESET_CYCLES < 1 || WDOG_CYCLES < 1 || CE_CYCLES < 1)
         $error("supervisor_reset_watchdog: cycle counts must be at least 1");
   end

   // ---------------------------------------------------------------
   // Input synchronisation
   // ---------------------------------------------------------------
   localparam int unsigned SYN_W = $bits(sense_type) + 4;
   logic [SYN_W-1:0] syn_in;
   logic [SYN_W-1:0] syn_out;
   sense_type        sense_s;
   logic             mr_n_s;
   logic             kick_s;
   logic             kick_float_s;
   logic             cs_s;

   assign syn_in = {sense_in, manual_reset_n, watchdog_kick_in, watchdog_kick_float,
                    chip_select_in};
   sync_bits #(.WIDTH(SYN_W)) u_sync (
      .core_clk (core_clk),
      .srst     (srst),
      .din      (syn_in),
      .dout     (syn_out)
   );
   assign {sense_s, mr_n_s, kick_s, kick_float_s, cs_s} = syn_out;

   // ---------------------------------------------------------------
   // Reset stretch
   // ---------------------------------------------------------------
   logic ctrl_swrst;
   logic rst_cause;
   logic rst_done;
   logic rst_act_r;
   assign rst_cause = sense_s.supply_below_rst || !mr_n_s || ctrl_swrst;

   // Any cause holds the counter at zero, so a dip restarts the full stretch
   delay_counter #(.WIDTH(CNT_W), .LIMIT(RESET_CYCLES)) u_rst_cnt (
      .core_clk (core_clk),
      .srst     (srst),
      .clear    (rst_cause),
      .run      (1'b1),
      .done     (rst_done)
   );

   always_ff @(posedge core_clk) begin
      if (srst) begin
         rst_act_r <= 1'b1;
      end else begin
         rst_act_r <= rst_cause || !rst_done;
      end
   end

   // ---------------------------------------------------------------
   // Watchdog
   // ---------------------------------------------------------------
   logic kick_d_r;
   logic kick_edge;
   logic wd_done;
   logic wd_fault_r;
   assign kick_edge = kick_s ^ kick_d_r;

   delay_counter #(.WIDTH(CNT_W), .LIMIT(WDOG_CYCLES)) u_wd_cnt (
      .core_clk (core_clk),
      .srst     (srst),
      .clear    (rst_act_r || kick_edge || kick_float_s),
      .run      (1'b1),
      .done     (wd_done)
   );

   always_ff @(posedge core_clk) begin
      if (srst) begin
         kick_d_r   <= 1'b0;
         wd_fault_r <= 1'b0;
      end else begin
         kick_d_r <= kick_s;
         if (rst_act_r || kick_float_s || kick_edge) begin
            wd_fault_r <= 1'b0;
         end else if (wd_done) begin
            wd_fault_r <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Chip-enable gate
   // ---------------------------------------------------------------
   logic ce_done;
   logic ce_en_r;
   delay_counter #(.WIDTH(CNT_W), .LIMIT(CE_CYCLES)) u_ce_cnt (
      .core_clk (core_clk),
      .srst     (srst),
      .clear    (!rst_act_r),
      .run      (1'b1),
      .done     (ce_done)
   );

   always_ff @(posedge core_clk) begin
      if (srst) begin
         ce_en_r <= 1'b0;
      end else if (!rst_act_r) begin
         ce_en_r <= 1'b1;
      end else if (ce_done) begin
         ce_en_r <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   logic backup_nxt;
   assign backup_nxt = sense_s.supply_below_rst && sense_s.supply_below_backup_cell_input;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         reset_out_n          <= 1'b0;
         reset_out            <= 1'b1;
         watchdog_fault_n     <= 1'b1;
         powerfail_warn_n     <= 1'b1;
         early_supply_warn_n  <= 1'b1;
         chip_select_out      <= 1'b1;
         backup_cell_selected <= 1'b0;
         backup_cell_good     <= 1'b0;
      end else begin
         reset_out_n          <= !rst_act_r;
         reset_out            <= rst_act_r;
         watchdog_fault_n     <= !wd_fault_r;
         powerfail_warn_n     <= !sense_s.pfail_below;
         early_supply_warn_n  <= !sense_s.supply_below_low;
         chip_select_out      <= ce_en_r ? cs_s : 1'b1;
         backup_cell_selected <= backup_nxt;
         backup_cell_good     <= !backup_nxt && sense_s.backup_cell_input_above_ok;
      end
   end

   // ---------------------------------------------------------------
   // Interrupt events
   // ---------------------------------------------------------------
   logic [EV_W-1:0] ev_lvl;
   logic [EV_W-1:0] ev_lvl_d_r;
   logic [EV_W-1:0] ev_set;
   logic [EV_W-1:0] irq_stat_r;
   logic [EV_W-1:0] irq_mask_r;
   logic [EV_W-1:0] w1c;
   logic [31:0]     ctrl_r;

   assign ev_lvl[EV_RESET]   = rst_act_r;
   assign ev_lvl[EV_WDOG]    = wd_fault_r;
   assign ev_lvl[EV_PFAIL]   = sense_s.pfail_below;
   assign ev_lvl[EV_LOWLINE] = sense_s.supply_below_low;
   assign ev_lvl[EV_BACKUP]  = backup_nxt;
   // Rising edges only, so a standing condition does not re-raise after clear
   assign ev_set     = ev_lvl & ~ev_lvl_d_r;
   assign ctrl_swrst = ctrl_r[CTRL_SWRST];

   // ---------------------------------------------------------------
   // AXI4-Lite slave
   // ---------------------------------------------------------------
   logic        aw_held_r;
   logic        w_held_r;
   logic [7:0]  awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0]  wstrb_r;
   logic        wr_go;
   logic        wr_hit;
   logic        rd_hit;
   logic [31:0] rd_mux;
   logic [31:0] status_word;

   assign wr_go = aw_held_r && w_held_r && !s_bvalid;
   assign wr_hit = (awaddr_r == ADDR_IRQ_STAT) || (awaddr_r == ADDR_IRQ_MASK) ||
                   (awaddr_r == ADDR_CONTROL) || (awaddr_r == ADDR_STATUS);
   assign w1c = (wr_go && awaddr_r == ADDR_IRQ_STAT && wstrb_r[0]) ?
                wdata_r[EV_W-1:0] : '0;
   assign status_word = {25'h000_0000, backup_nxt, sense_s.backup_cell_input_above_ok,
                         sense_s.pfail_below, sense_s.supply_below_low,
                         ce_en_r, wd_fault_r, rst_act_r};
   assign rd_hit = (s_araddr == ADDR_STATUS) || (s_araddr == ADDR_IRQ_STAT) ||
                   (s_araddr == ADDR_IRQ_MASK) || (s_araddr == ADDR_CONTROL);
   assign rd_mux = (s_araddr == ADDR_STATUS)   ? status_word :
                   (s_araddr == ADDR_IRQ_STAT) ? {27'h000_0000, irq_stat_r} :
                   (s_araddr == ADDR_IRQ_MASK) ? {27'h000_0000, irq_mask_r} :
                   (s_araddr == ADDR_CONTROL)  ? ctrl_r : 32'h0000_0000;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         aw_held_r  <= 1'b0;
         w_held_r   <= 1'b0;
         awaddr_r   <= 8'h00;
         wdata_r    <= 32'h0000_0000;
         wstrb_r    <= 4'h0;
         s_bvalid   <= 1'b0;
         s_bresp    <= RESP_OKAY;
      end else begin
         if (s_awvalid && s_awready) begin
            aw_held_r <= 1'b1;
            awaddr_r  <= s_awaddr;
         end
         if (s_wvalid && s_wready) begin
            w_held_r <= 1'b1;
            wdata_r  <= s_wdata;
            wstrb_r  <= s_wstrb;
         end
         if (wr_go) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            s_bvalid  <= 1'b1;
            s_bresp   <= wr_hit ? RESP_OKAY : RESP_DECERR;
         end else if (s_bvalid && s_bready) begin
            s_bvalid <= 1'b0;
         end
      end
   end
   assign s_awready = !aw_held_r && !s_bvalid;
   assign s_wready  = !w_held_r && !s_bvalid;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         s_arready <= 1'b0;
         s_rvalid  <= 1'b0;
         s_rdata   <= 32'h0000_0000;
         s_rresp   <= RESP_OKAY;
      end else begin
         s_arready <= !s_rvalid && !s_arready && s_arvalid;
         if (s_arvalid && s_arready) begin
            s_rvalid <= 1'b1;
            s_rdata  <= rd_mux;
            s_rresp  <= rd_hit ? RESP_OKAY : RESP_DECERR;
         end else if (s_rvalid && s_rready) begin
            s_rvalid <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Register storage and interrupt output
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (srst) begin
         ev_lvl_d_r <= '0;
         irq_stat_r <= '0;
         irq_mask_r <= MASK_RST;
         ctrl_r     <= CTRL_RST;
         irq        <= 1'b0;
      end else begin
         ev_lvl_d_r <= ev_lvl;
         // Set wins over a clear in the same cycle
         irq_stat_r <= (irq_stat_r & ~w1c) | ev_set;
         if (wr_go && awaddr_r == ADDR_IRQ_MASK && wstrb_r[0]) begin
            irq_mask_r <= wdata_r[EV_W-1:0];
         end
         if (wr_go && awaddr_r == ADDR_CONTROL && wstrb_r[0]) begin
            ctrl_r[7:0] <= wdata_r[7:0];
         end
         irq <= |(((irq_stat_r & ~w1c) | ev_set) & ~irq_mask_r);
      end
   end
endmodule : supervisor_reset_watchdog

// File: tb/supervisor_checker.sv
// Checker: timing relations at the supervisor top ports
`timescale 1ns/1ps
module supervisor_checker
   import supervisor_pkg::*;
#(
   parameter int unsigned RESET_CYCLES = 50,
   parameter int unsigned WDOG_CYCLES  = 400,
   parameter int unsigned CE_CYCLES    = 7
) (
   // Clock and reset
   input wire logic                      core_clk,
   input wire logic                      srst,
   // Inputs
   input wire supervisor_pkg::sense_type sense_in,
   input wire logic                      manual_reset_n,
   input wire logic                      watchdog_kick_in,
   input wire logic                      watchdog_kick_float,
   input wire logic                      chip_select_in,
   // Outputs
   input wire logic                      reset_out_n,
   input wire logic                      reset_out,
   input wire logic                      watchdog_fault_n,
   input wire logic                      powerfail_warn_n,
   input wire logic                      early_supply_warn_n,
   input wire logic                      chip_select_out,
   input wire logic                      backup_cell_selected,
   input wire logic                      backup_cell_good
);
   logic [31:0] quiet_r;
   logic [31:0] idle_r;
   logic [31:0] low_r;
   logic        kick_r;
   wire         cause   = !manual_reset_n || sense_in.supply_below_rst;
   wire         kicked  = kick_r != watchdog_kick_in;
   wire         on_backup_cell_input = sense_in.supply_below_rst && sense_in.supply_below_backup_cell_input;
   always_ff @(posedge core_clk) begin
      kick_r  <= watchdog_kick_in;
      quiet_r <= (srst || cause) ? 32'h0 : quiet_r + 32'h1;
      idle_r  <= (srst || !reset_out_n || watchdog_kick_float || kicked) ? 32'h0 : idle_r + 32'h1;
      low_r   <= (srst || reset_out_n) ? 32'h0 : low_r + 32'h1;
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);
   a_reset_inverse: assert property (reset_out == !reset_out_n)
      else $error("reset pair mismatch");
   a_manual_reset: assert property ((!manual_reset_n)[*6] |-> !reset_out_n)
      else $error("no manual reset");
   a_supply_reset: assert property (sense_in.supply_below_rst[*6] |-> !reset_out_n)
      else $error("no supply reset");
   a_stretch_min: assert property ($rose(reset_out_n) |-> quiet_r >= RESET_CYCLES)
      else $error("stretch short");
   a_stretch_max: assert property (quiet_r == RESET_CYCLES + 10 |-> reset_out_n)
      else $error("stretch long");
   a_fault_in_reset: assert property ((!reset_out_n)[*3] |-> watchdog_fault_n)
      else $error("fault in reset");
   a_wdog_early: assert property ($fell(watchdog_fault_n) |-> idle_r >= WDOG_CYCLES - 4)
      else $error("fault early");
   a_wdog_late: assert property (idle_r == WDOG_CYCLES + 10 |-> !watchdog_fault_n)
      else $error("fault missing");
   a_wdog_float: assert property (watchdog_kick_float[*6] |-> watchdog_fault_n)
      else $error("fault while float");
   a_ce_gate_off: assert property (low_r > CE_CYCLES + 3 |-> chip_select_out)
      else $error("select ungated");
   a_ce_pass: assert property ((reset_out_n && $stable(chip_select_in))[*4]
      |-> chip_select_out == chip_select_in) else $error("select not passed");
   a_pfail_follow: assert property ($stable(sense_in)[*7]
      |-> powerfail_warn_n == !sense_in.pfail_below) else $error("power-fail wrong");
   a_lowline_follow: assert property ($stable(sense_in)[*7]
      |-> early_supply_warn_n == !sense_in.supply_below_low) else $error("low-line wrong");
   a_backup_select: assert property ($stable(sense_in)[*7]
      |-> backup_cell_selected == on_backup_cell_input) else $error("backup wrong");
   a_backup_good: assert property ($stable(sense_in)[*7]
      |-> backup_cell_good == (sense_in.backup_cell_input_above_ok && !on_backup_cell_input)) else $error("good wrong");
   c_reset_release: cover property ($rose(reset_out_n));
   c_wdog_fault: cover property ($fell(watchdog_fault_n));
   c_backup_on: cover property ($rose(backup_cell_selected));
endmodule : supervisor_checker

// File: tb/cpu_ram_model.sv
// Far-side model: processor kicking the watchdog and selecting the RAM
`timescale 1ns/1ps
module cpu_ram_model #(
   parameter int unsigned KICK_GAP = 50
) (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic srst,
   // Bench control and supervisor state
   input  wire logic kick_en,
   input  wire logic reset_out_n,
   // Pins toward the supervisor
   output logic      watchdog_kick_in,
   output logic      chip_select_in
);
   logic [7:0] gap_r;
   logic [3:0] cs_r;
   // Kicks only once out of reset
   wire        kick_now = kick_en && reset_out_n && (gap_r == 8'(KICK_GAP - 1));
   wire        restart  = srst || !kick_en || !reset_out_n || kick_now;
   always_ff @(posedge core_clk) begin
      gap_r            <= restart ? 8'h00 : gap_r + 8'h01;
      watchdog_kick_in <= srst ? 1'b0 : watchdog_kick_in ^ kick_now;
      cs_r             <= srst ? 4'h0 : cs_r + 4'h1;
   end
   assign chip_select_in = cs_r[3];
endmodule : cpu_ram_model

// File: tb/supervisor_reset_watchdog_bench.sv
// Bench: directed tests of the supervisor
`timescale 1ns/1ps
module supervisor_reset_watchdog_bench;
   import supervisor_pkg::*;
   localparam int unsigned RST_C = 50;
   localparam int unsigned WD_C  = 400;
   sense_type   sense = 5'h02;
   logic        core_clk = 1'b0;
   logic        srst = 1'b1;
   logic        manual_reset_n = 1'b1;
   logic        kick_en = 1'b0;
   logic        watchdog_kick_float = 1'b0;
   logic        watchdog_kick_in, chip_select_in, reset_out_n, reset_out, watchdog_fault_n;
   logic        powerfail_warn_n, early_supply_warn_n, chip_select_out;
   logic        backup_cell_selected, backup_cell_good, irq;
   logic [7:0]  s_awaddr = 8'h00, s_araddr = 8'h00;
   logic [31:0] s_wdata = 32'h0000_0000, s_rdata, rd;
   logic [3:0]  s_wstrb = 4'h0;
   logic        s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
   logic        s_arvalid = 1'b0, s_rready = 1'b0;
   logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
   logic [1:0]  s_bresp, s_rresp, rsp;
   int          errors = 0, tests_run = 0;
   always #20 core_clk = ~core_clk;
   supervisor_reset_watchdog #(.RESET_CYCLES(RST_C), .WDOG_CYCLES(WD_C), .CE_CYCLES(7)) dut_u (
      .core_clk, .srst, .sense_in(sense), .manual_reset_n, .watchdog_kick_in,
      .watchdog_kick_float, .chip_select_in, .reset_out_n, .reset_out, .watchdog_fault_n,
      .powerfail_warn_n, .early_supply_warn_n, .chip_select_out, .backup_cell_selected,
      .backup_cell_good, .irq, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
      .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
      .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready);
   cpu_ram_model #(.KICK_GAP(50)) cpu_u (.core_clk, .srst, .kick_en, .reset_out_n,
      .watchdog_kick_in, .chip_select_in);
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask : tick
   task automatic at(input int n);
      tick(n);
      @(negedge core_clk);
   endtask : at
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic give_verdict();
      $display("checks=%0d mismatches=%0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : give_verdict
   task automatic expect_release();
      at(40);
      chk(reset_out_n, 1'b0);
      at(20);
      chk(reset_out_n, 1'b1);
   endtask : expect_release
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge core_clk);
      {s_awaddr, s_wdata, s_wstrb} <= {a, d, 4'hf};
      {s_awvalid, s_wvalid, s_bready} <= 3'b111;
      do begin
         @(posedge core_clk);
         n++;
         if (s_awready) s_awvalid <= 1'b0;
         if (s_wready) s_wvalid <= 1'b0;
         if (s_bvalid) {rsp, s_bready} <= {s_bresp, 1'b0};
      end while (s_bready && n < 100);
      if (n >= 100) errors++;
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a);
      int n = 0;
      @(posedge core_clk);
      {s_araddr, s_arvalid, s_rready} <= {a, 2'b11};
      do begin
         @(posedge core_clk);
         n++;
         if (s_arready) s_arvalid <= 1'b0;
         if (s_rvalid) {rsp, rd, s_rready} <= {s_rresp, s_rdata, 1'b0};
      end while (s_rready && n < 100);
      if (n >= 100) errors++;
   endtask : axi_rd
   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial begin
      tick(2);
      srst <= 1'b0;
      at(1);
      chk(chip_select_out, 1'b1);
      expect_release();
      chk(backup_cell_good, 1'b1);
      $display("power-on stretch done");
      tick(1);
      sense <= 5'h16;
      at(8);
      chk(backup_cell_selected, 1'b1);
      chk(backup_cell_good, 1'b0);
      chk(reset_out, 1'b1);
      tick(2);
      sense <= 5'h02;
      at(30);
      tick(1);
      sense <= 5'h12;
      at(6);
      chk(backup_cell_selected, 1'b0);
      tick(1);
      sense <= 5'h02;
      expect_release();
      $display("supply dip done");
      tick(1);
      manual_reset_n <= 1'b0;
      at(20);
      chk(chip_select_out, 1'b1);
      tick(1);
      manual_reset_n <= 1'b1;
      expect_release();
      wait (chip_select_in);
      wait (!chip_select_in);
      at(3);
      chk(chip_select_out, 1'b0);
      $display("manual reset done");
      for (int i = 0; i < 2; i++) begin
         tick(1);
         sense[3*i] <= 1'b1;
         at(8);
         chk({powerfail_warn_n, early_supply_warn_n}, i ? 2'b10 : 2'b01);
         tick(1);
         sense[3*i] <= 1'b0;
         at(8);
         chk({powerfail_warn_n, early_supply_warn_n}, 2'b11);
      end
      tick(1);
      sense.backup_cell_input_above_ok <= 1'b0;
      at(8);
      chk(backup_cell_good, 1'b0);
      tick(1);
      sense <= 5'h02;
      $display("warnings done");
      kick_en <= 1'b1;
      at(600);
      chk(watchdog_fault_n, 1'b1);
      @(watchdog_kick_in);
      tick(1);
      kick_en <= 1'b0;
      at(WD_C - 30);
      chk(watchdog_fault_n, 1'b1);
      at(50);
      chk(watchdog_fault_n, 1'b0);
      tick(1);
      kick_en <= 1'b1;
      at(70);
      chk(watchdog_fault_n, 1'b1);
      tick(1);
      kick_en <= 1'b0;
      at(WD_C + 60);
      manual_reset_n <= 1'b0;
      at(8);
      chk(watchdog_fault_n, 1'b1);
      tick(1);
      manual_reset_n <= 1'b1;
      watchdog_kick_float <= 1'b1;
      at(WD_C + 120);
      chk(watchdog_fault_n, 1'b1);
      tick(1);
      watchdog_kick_float <= 1'b0;
      kick_en <= 1'b1;
      $display("watchdog done");
      axi_rd(ADDR_IRQ_MASK);
      chk(rd, 32'(MASK_RST));
      axi_rd(8'h10);
      chk(rsp, RESP_DECERR);
      chk(rd, 32'h0000_0000);
      axi_wr(8'h14, 32'h0000_001f);
      chk(rsp, RESP_DECERR);
      chk(irq, 1'b0);
      axi_wr(ADDR_IRQ_MASK, 32'h0000_0000);
      at(3);
      chk(irq, 1'b1);
      axi_wr(ADDR_IRQ_STAT, 32'h0000_001f);
      chk(rsp, RESP_OKAY);
      at(3);
      chk(irq, 1'b0);
      tick(1);
      sense.pfail_below <= 1'b1;
      at(8);
      axi_rd(ADDR_IRQ_STAT);
      chk(rd, 32'h0000_0004);
      chk(irq, 1'b1);
      axi_wr(ADDR_IRQ_MASK, 32'h0000_0004);
      at(3);
      chk(irq, 1'b0);
      $display("registers done");
      give_verdict();
   end
   initial begin
      #(40 * 10000);
      errors++;
      give_verdict();
   end
endmodule : supervisor_reset_watchdog_bench
bind supervisor_reset_watchdog supervisor_checker #(.RESET_CYCLES(RESET_CYCLES),
   .WDOG_CYCLES(WDOG_CYCLES), .CE_CYCLES(CE_CYCLES)) chk_u (.core_clk, .srst, .sense_in,
   .manual_reset_n, .watchdog_kick_in, .watchdog_kick_float, .chip_select_in, .reset_out_n,
   .reset_out, .watchdog_fault_n, .powerfail_warn_n, .early_supply_warn_n, .chip_select_out,
   .backup_cell_selected, .backup_cell_good);
